// >>> bcr_pkg.sv
// bcr_pkg: register selects, field positions, reset values for the bias control register bank
// assumes: a serial front end outside delivers decoded 16-bit word writes and read selects
package bcr_pkg;

	// ====================================================================
	// register selects (command codes are decoded by the serial front end)
	localparam logic [3:0] SEL_ALARM_CFG = 4'h0;
	localparam logic [3:0] SEL_SCAN_CTRL = 4'h1;
	localparam logic [3:0] SEL_SHUTDOWN  = 4'h2;
	localparam logic [3:0] SEL_LOAD      = 4'h3;
	localparam logic [3:0] SEL_CLEAR     = 4'h4;
	localparam logic [3:0] SEL_THRU_HI1  = 4'h5;
	localparam logic [3:0] SEL_THRU_HI2  = 4'h6;
	localparam logic [3:0] SEL_THRU_LO1  = 4'h7;
	localparam logic [3:0] SEL_THRU_LO2  = 4'h8;
	localparam logic [3:0] SEL_WIPE_HI1  = 4'h9;
	localparam logic [3:0] SEL_WIPE_HI2  = 4'hA;
	localparam logic [3:0] SEL_WIPE_LO1  = 4'hB;
	localparam logic [3:0] SEL_WIPE_LO2  = 4'hC;
	localparam logic [3:0] SEL_FINE_CH1  = 4'hD;
	localparam logic [3:0] SEL_FINE_CH2  = 4'hE;
	localparam logic [3:0] SEL_FINECAL   = 4'hF;

	// ====================================================================
	// field positions
	localparam int ALM_FORCE1   = 7;
	localparam int ALM_FORCE2   = 6;
	localparam int ALM_POL      = 5;
	localparam int ALM_OPN      = 4;
	localparam int ALM_P1POL    = 3;
	localparam int ALM_P1OPN    = 2;
	localparam int ALM_P2POL    = 1;
	localparam int ALM_P2OPN    = 0;
	localparam int SCAN_REPEAT  = 7;
	localparam int SD_GLOBAL    = 7;
	localparam int SD_REF_ON    = 3;
	localparam int SD_OSC_PD    = 2;
	localparam int SD_DAC2_PD   = 1;
	localparam int SD_DAC1_PD   = 0;
	localparam int LD_FINE_CH2  = 5;
	localparam int LD_HI2       = 4;
	localparam int LD_LO2       = 3;
	localparam int LD_FINE_CH1  = 2;
	localparam int LD_HI1       = 1;
	localparam int LD_LO1       = 0;
	localparam int CL_TOTAL     = 9;
	localparam int CL_ARM       = 8;
	localparam int CL_QUEUE     = 6;
	localparam int CL_HI2       = 5;
	localparam int CL_LO2       = 4;
	localparam int CL_FINE_CH1  = 3;
	localparam int CL_HI1       = 2;
	localparam int CL_LO1       = 1;
	localparam int CL_FINE_CH2  = 0;
	localparam int WIPE_CAL     = 15;

	// ====================================================================
	// reset values and the reserved scan bit mask
	localparam logic [7:0]  ALM_RST      = 8'h00;
	localparam logic [7:0]  SCAN_RST     = 8'h00;
	localparam logic [7:0]  SHUT_RST     = 8'h83;
	localparam logic [8:0]  WIPE_IN_RST  = 9'h100;
	localparam logic [7:0]  CODE8_RST    = 8'h00;
	localparam logic [9:0]  CODE10_RST   = 10'h000;
	localparam logic [15:0] SCAN_RSV_MSK = 16'h0F00;

endpackage : bcr_pkg

// >>> bcr_pin_drv.sv
// bcr_pin_drv: polarity and drive-type stage for one alarm or protect pin
// assumes: the pad combines out and oe; a released open-drain pin is pulled up outside
module bcr_pin_drv
	import bcr_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic active,
	input  wire logic active_low,
	input  wire logic open_drain,
	output logic      pin_out,
	output logic      pin_oe
);

	typedef struct packed {
		logic lvl;
		logic oe;
	} bcr_pin_s;

	bcr_pin_s st_reg;
	bcr_pin_s st_next;
	logic     lvl;

	// ====================================================================
	// level and enable
	always_comb
	begin
		lvl        = active ^ active_low;
		st_next.lvl = lvl;
		// open drain only ever pulls low
		st_next.oe  = open_drain ? ~lvl : 1'b1;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= '{lvl: 1'b0, oe: 1'b1};
		else
			st_reg <= st_next;
	end

	assign pin_out = st_reg.oe ? st_reg.lvl : 1'b0;
	assign pin_oe  = st_reg.oe;

	a_pin_open_drain : assert property (@(posedge core_clk) disable iff (!rst_n) // R2 R3
		$past(open_drain) |-> !(pin_oe && pin_out))
		else $error("open drain pin drove high");

endmodule : bcr_pin_drv

// >>> bcr_regs.sv
// bcr_regs: control register bank of a dual channel bias controller
// assumes: serial front end gives one-cycle wr_en with wr_sel/wr_data, and rd_sel for reads
// Operation
// R1: force bit drives that channel's protect output active at once
// R2: alert polarity bit picks active low; drive bit picks open drain
// R3: each protect pin has own polarity and drive bit, all zero at reset
// R4: host writes zeros to the four reserved scan bits
// R5: repeat bit makes the converter loop its scan, else one scan
// R6: seven select bits each add one converter source to the scan
// R7: fine load copies the latest written of plain or calibrated input
// R8: upper load moves upper input to output; autocal if its cal bit set
// R9: lower load moves lower input to output; autocal if its cal bit set
// R10: clear bits return matching input and output to power-on values
// R11: full reset needs arm write then total-reset write, back to back
// R12: after full reset device is shut down until shutdown register written
// R13: queue clear bit empties result queue and its flags
// R14: global power-down shuts all blocks, set at power-on
// R15: reference force bit keeps the bandgap on, else converter controls it
// R16: oscillator power-down bit stops the oscillator
// R17: per-channel converter off bits, both set at reset
// R18: upper write-through updates output at once, no strobe, no autocal
// R19: lower write-through updates output at once, no strobe, no autocal
// R20: write-through registers read back their stored contents
// R21: load strobes self-clear right after the write
// R22: leaving global power-down takes two writes; first ignores other bits
// R23: wiper input top bit enables autocal, default one; low byte is code
// R24: several strobes in one write update outputs in the same cycle
// R25: clear beats load on the same converter
module bcr_regs
	import bcr_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        wr_en,
	input  wire logic [3:0]  wr_sel,
	input  wire logic [15:0] wr_data,
	input  wire logic        wr_fine_ch,
	input  wire logic [3:0]  rd_sel,
	output logic      [15:0] rd_data,
	input  wire logic        fault_ch1,
	input  wire logic        fault_ch2,
	input  wire logic        alert_active,
	output logic             protect_out_ch1,
	output logic             protect_oe_ch1,
	output logic             protect_out_ch2,
	output logic             protect_oe_ch2,
	output logic             alert_out,
	output logic             alert_oe,
	output logic             repeat_scan,
	output logic      [6:0]  scan_select,
	output logic             scan_start,
	output logic             result_queue_clear,
	output logic             global_powerdown,
	output logic             reference_force_on,
	output logic             oscillator_powerdown,
	output logic             converter_off_ch1,
	output logic             converter_off_ch2,
	output logic      [7:0]  upper_wiper_out_ch1,
	output logic      [7:0]  upper_wiper_out_ch2,
	output logic      [7:0]  lower_wiper_out_ch1,
	output logic      [7:0]  lower_wiper_out_ch2,
	output logic      [9:0]  fine_out_ch1,
	output logic      [9:0]  fine_out_ch2,
	output logic      [1:0]  fine_cal_apply,
	output logic      [3:0]  wiper_autocal_start
);

	typedef struct packed {
		logic [7:0]      alm;
		logic [7:0]      scan;
		logic [7:0]      shut;
		logic            armed;
		logic [1:0][8:0] hi_in;
		logic [1:0][8:0] lo_in;
		logic [1:0][7:0] hi_thru;
		logic [1:0][7:0] lo_thru;
		logic [1:0][7:0] hi_out;
		logic [1:0][7:0] lo_out;
		logic [1:0][9:0] fine_plain;
		logic [1:0][9:0] fine_cal;
		logic [1:0]      fine_last_cal;
		logic [1:0][9:0] fine_out;
		logic [1:0]      cal_apply;
		logic [3:0]      autocal;
		logic            scan_go;
		logic            q_clr;
	} bcr_state_s;

	bcr_state_s st_reg;
	bcr_state_s st_next;
	logic [1:0] rst_sync_reg;
	logic       rst_n;
	logic [5:0] ld;
	logic [5:0] cl;
	logic       total_rst;

	// ====================================================================
	// reset release
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			rst_sync_reg <= 2'b00;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	function automatic bcr_state_s por_state();
		bcr_state_s s;
		s               = '0;
		s.alm           = ALM_RST;
		s.scan          = SCAN_RST;
		s.shut          = SHUT_RST;
		s.hi_in         = {2{WIPE_IN_RST}};
		s.lo_in         = {2{WIPE_IN_RST}};
		return s;
	endfunction : por_state

	// ====================================================================
	// write decode
	always_comb
	begin
		st_next           = st_reg;
		st_next.autocal   = 4'h0;
		st_next.scan_go   = 1'b0;
		st_next.q_clr     = 1'b0;
		ld                = 6'h00;
		cl                = 6'h00;
		total_rst         = 1'b0;
		if (wr_en)
		begin
			if (wr_sel != SEL_CLEAR)
				st_next.armed = 1'b0; // R11
			case (wr_sel)
				SEL_ALARM_CFG: st_next.alm = wr_data[7:0];
				SEL_SCAN_CTRL:
				begin
					st_next.scan    = wr_data[7:0]; // R5 R6
					st_next.scan_go = 1'b1;
				end
				SEL_SHUTDOWN:
				begin
					// first write out of power-down only drops the global bit
					if (st_reg.shut[SD_GLOBAL])
						st_next.shut[SD_GLOBAL] = wr_data[SD_GLOBAL]; // R22
					else
						st_next.shut = wr_data[7:0]; // R14 R15 R16 R17
				end
				SEL_LOAD: ld = wr_data[5:0]; // R21
				SEL_CLEAR:
				begin
					cl            = wr_data[5:0];
					st_next.q_clr = wr_data[CL_QUEUE]; // R13
					total_rst     = st_reg.armed && wr_data[CL_TOTAL] && !wr_data[CL_ARM];
					st_next.armed = wr_data[CL_ARM] && !wr_data[CL_TOTAL]; // R11
				end
				SEL_THRU_HI1, SEL_THRU_HI2:
				begin
					st_next.hi_thru[wr_sel[0] ? 0 : 1] = wr_data[7:0];
					st_next.hi_out[wr_sel[0] ? 0 : 1]  = wr_data[7:0]; // R18
				end
				SEL_THRU_LO1, SEL_THRU_LO2:
				begin
					st_next.lo_thru[wr_sel[0] ? 0 : 1] = wr_data[7:0];
					st_next.lo_out[wr_sel[0] ? 0 : 1]  = wr_data[7:0]; // R19
				end
				SEL_WIPE_HI1, SEL_WIPE_HI2:
					st_next.hi_in[wr_sel[0] ? 0 : 1] = {wr_data[WIPE_CAL], wr_data[7:0]}; // R23
				SEL_WIPE_LO1, SEL_WIPE_LO2:
					st_next.lo_in[wr_sel[0] ? 0 : 1] = {wr_data[WIPE_CAL], wr_data[7:0]}; // R23
				SEL_FINE_CH1, SEL_FINE_CH2:
				begin
					st_next.fine_plain[wr_sel[0] ? 0 : 1]    = wr_data[9:0];
					st_next.fine_last_cal[wr_sel[0] ? 0 : 1] = 1'b0;
				end
				SEL_FINECAL:
				begin
					st_next.fine_cal[wr_fine_ch]      = wr_data[9:0];
					st_next.fine_last_cal[wr_fine_ch] = 1'b1;
				end
				default: st_next.armed = 1'b0;
			endcase
		end
		// all strobes act in this one cycle
		if (ld[LD_HI1])
		begin
			st_next.hi_out[0]  = st_reg.hi_in[0][7:0]; // R8 R24
			st_next.autocal[0] = st_reg.hi_in[0][8];
		end
		if (ld[LD_HI2])
		begin
			st_next.hi_out[1]  = st_reg.hi_in[1][7:0]; // R8 R24
			st_next.autocal[1] = st_reg.hi_in[1][8];
		end
		if (ld[LD_LO1])
		begin
			st_next.lo_out[0]  = st_reg.lo_in[0][7:0]; // R9
			st_next.autocal[2] = st_reg.lo_in[0][8];
		end
		if (ld[LD_LO2])
		begin
			st_next.lo_out[1]  = st_reg.lo_in[1][7:0]; // R9
			st_next.autocal[3] = st_reg.lo_in[1][8];
		end
		if (ld[LD_FINE_CH1])
		begin
			st_next.fine_out[0]  = st_reg.fine_last_cal[0] ? st_reg.fine_cal[0]
				: st_reg.fine_plain[0]; // R7
			st_next.cal_apply[0] = st_reg.fine_last_cal[0];
		end
		if (ld[LD_FINE_CH2])
		begin
			st_next.fine_out[1]  = st_reg.fine_last_cal[1] ? st_reg.fine_cal[1]
				: st_reg.fine_plain[1]; // R7
			st_next.cal_apply[1] = st_reg.fine_last_cal[1];
		end
		// clears after loads so the clear wins
		if (cl[CL_HI1])
		begin
			st_next.hi_in[0]   = WIPE_IN_RST; // R10 R25
			st_next.hi_out[0]  = CODE8_RST;
			st_next.autocal[0] = 1'b0;
		end
		if (cl[CL_HI2])
		begin
			st_next.hi_in[1]   = WIPE_IN_RST; // R10 R25
			st_next.hi_out[1]  = CODE8_RST;
			st_next.autocal[1] = 1'b0;
		end
		if (cl[CL_LO1])
		begin
			st_next.lo_in[0]   = WIPE_IN_RST; // R10 R25
			st_next.lo_out[0]  = CODE8_RST;
			st_next.autocal[2] = 1'b0;
		end
		if (cl[CL_LO2])
		begin
			st_next.lo_in[1]   = WIPE_IN_RST; // R10 R25
			st_next.lo_out[1]  = CODE8_RST;
			st_next.autocal[3] = 1'b0;
		end
		if (cl[CL_FINE_CH1])
		begin
			st_next.fine_plain[0]    = CODE10_RST; // R10 R25
			st_next.fine_cal[0]      = CODE10_RST;
			st_next.fine_last_cal[0] = 1'b0;
			st_next.fine_out[0]      = CODE10_RST;
			st_next.cal_apply[0]     = 1'b0;
		end
		if (cl[CL_FINE_CH2])
		begin
			st_next.fine_plain[1]    = CODE10_RST; // R10 R25
			st_next.fine_cal[1]      = CODE10_RST;
			st_next.fine_last_cal[1] = 1'b0;
			st_next.fine_out[1]      = CODE10_RST;
			st_next.cal_apply[1]     = 1'b0;
		end
		if (total_rst)
		begin
			st_next       = por_state(); // R11 R12
			st_next.q_clr = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= por_state();
		else
			st_reg <= st_next;
	end

	// ====================================================================
	// read back
	always_comb
	begin
		case (rd_sel)
			SEL_ALARM_CFG: rd_data = {8'h00, st_reg.alm};
			SEL_THRU_HI1:  rd_data = {8'h00, st_reg.hi_thru[0]}; // R20
			SEL_THRU_HI2:  rd_data = {8'h00, st_reg.hi_thru[1]}; // R20
			SEL_THRU_LO1:  rd_data = {8'h00, st_reg.lo_thru[0]}; // R20
			SEL_THRU_LO2:  rd_data = {8'h00, st_reg.lo_thru[1]}; // R20
			SEL_WIPE_HI1:  rd_data = {st_reg.hi_in[0][8], 7'h00, st_reg.hi_in[0][7:0]};
			SEL_WIPE_HI2:  rd_data = {st_reg.hi_in[1][8], 7'h00, st_reg.hi_in[1][7:0]};
			SEL_WIPE_LO1:  rd_data = {st_reg.lo_in[0][8], 7'h00, st_reg.lo_in[0][7:0]};
			SEL_WIPE_LO2:  rd_data = {st_reg.lo_in[1][8], 7'h00, st_reg.lo_in[1][7:0]};
			default:       rd_data = 16'h0000;
		endcase
	end

	// ====================================================================
	// outputs
	assign repeat_scan          = st_reg.scan[SCAN_REPEAT];
	assign scan_select          = st_reg.scan[6:0];
	assign scan_start           = st_reg.scan_go;
	assign result_queue_clear   = st_reg.q_clr;
	assign global_powerdown     = st_reg.shut[SD_GLOBAL];
	// global power-down overrides, retained bits come back after
	assign reference_force_on   = st_reg.shut[SD_REF_ON] & ~st_reg.shut[SD_GLOBAL];
	assign oscillator_powerdown = st_reg.shut[SD_OSC_PD] | st_reg.shut[SD_GLOBAL];
	assign converter_off_ch1    = st_reg.shut[SD_DAC1_PD] | st_reg.shut[SD_GLOBAL];
	assign converter_off_ch2    = st_reg.shut[SD_DAC2_PD] | st_reg.shut[SD_GLOBAL];
	assign upper_wiper_out_ch1  = st_reg.hi_out[0];
	assign upper_wiper_out_ch2  = st_reg.hi_out[1];
	assign lower_wiper_out_ch1  = st_reg.lo_out[0];
	assign lower_wiper_out_ch2  = st_reg.lo_out[1];
	assign fine_out_ch1         = st_reg.fine_out[0];
	assign fine_out_ch2         = st_reg.fine_out[1];
	assign fine_cal_apply       = st_reg.cal_apply;
	assign wiper_autocal_start  = st_reg.autocal;

	bcr_pin_drv u_prot1 (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.active     (st_reg.alm[ALM_FORCE1] | fault_ch1), // R1
		.active_low (st_reg.alm[ALM_P1POL]), // R3
		.open_drain (st_reg.alm[ALM_P1OPN]),
		.pin_out    (protect_out_ch1),
		.pin_oe     (protect_oe_ch1)
	);
	bcr_pin_drv u_prot2 (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.active     (st_reg.alm[ALM_FORCE2] | fault_ch2), // R1
		.active_low (st_reg.alm[ALM_P2POL]), // R3
		.open_drain (st_reg.alm[ALM_P2OPN]),
		.pin_out    (protect_out_ch2),
		.pin_oe     (protect_oe_ch2)
	);
	bcr_pin_drv u_alert (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.active     (alert_active),
		.active_low (st_reg.alm[ALM_POL]), // R2
		.open_drain (st_reg.alm[ALM_OPN]),
		.pin_out    (alert_out),
		.pin_oe     (alert_oe)
	);

	// ====================================================================
	// checks
	a_force_prot1 : assert property (@(posedge core_clk) disable iff (!rst_n) // R1
		st_reg.alm[ALM_FORCE1] && $stable(st_reg.alm) |=> (protect_oe_ch1 ? protect_out_ch1 : 1'b1)
		== ~$past(st_reg.alm[ALM_P1POL]))
		else $error("protect ch1 not forced");
	a_load_upper : assert property (@(posedge core_clk) disable iff (!rst_n) // R8
		wr_en && wr_sel == SEL_LOAD && wr_data[LD_HI1] && !(0)
		|=> upper_wiper_out_ch1 == $past(st_reg.hi_in[0][7:0])
		&& wiper_autocal_start[0] == $past(st_reg.hi_in[0][8]))
		else $error("upper load wrong");
	a_clear_wins : assert property (@(posedge core_clk) disable iff (!rst_n) // R25
		wr_en && wr_sel == SEL_CLEAR && wr_data[CL_LO1] |=> lower_wiper_out_ch1 == CODE8_RST)
		else $error("clear lost");
	a_thru_upper : assert property (@(posedge core_clk) disable iff (!rst_n) // R18
		wr_en && wr_sel == SEL_THRU_HI2 |=> upper_wiper_out_ch2 == $past(wr_data[7:0])
		&& !wiper_autocal_start[1])
		else $error("write-through wrong");
	a_strobe_pulse : assert property (@(posedge core_clk) disable iff (!rst_n) // R21
		wiper_autocal_start != 4'h0 |=> wiper_autocal_start == 4'h0 || $past(wr_en))
		else $error("strobe stuck");
	a_total_reset : assert property (@(posedge core_clk) disable iff (!rst_n) // R11
		wr_en && wr_sel == SEL_CLEAR && wr_data[CL_TOTAL] && !wr_data[CL_ARM] && st_reg.armed
		|=> global_powerdown && converter_off_ch1 && st_reg.shut == SHUT_RST)
		else $error("full reset failed");
	a_pd_exit : assert property (@(posedge core_clk) disable iff (!rst_n) // R22
		wr_en && wr_sel == SEL_SHUTDOWN && global_powerdown
		|=> st_reg.shut[6:0] == $past(st_reg.shut[6:0]))
		else $error("power-down exit took extra bits");
	a_fine_latest : assert property (@(posedge core_clk) disable iff (!rst_n) // R7
		wr_en && wr_sel == SEL_LOAD && wr_data[LD_FINE_CH1] && st_reg.fine_last_cal[0]
		|=> fine_out_ch1 == $past(st_reg.fine_cal[0]) && fine_cal_apply[0])
		else $error("fine load source wrong");
	c_total_reset : cover property (@(posedge core_clk) disable iff (!rst_n)
		st_reg.armed ##1 global_powerdown);
	c_multi_load  : cover property (@(posedge core_clk) disable iff (!rst_n)
		wr_en && wr_sel == SEL_LOAD && wr_data[5:0] == 6'h3F);
	c_thru_read   : cover property (@(posedge core_clk) disable iff (!rst_n)
		rd_sel == SEL_THRU_LO1 && rd_data != 16'h0000);

endmodule : bcr_regs

// >>> bcr_host_model.sv
// bcr_host_model: host side of the bank, issuing decoded word writes
// assumes: the bench calls its tasks at a falling edge of core_clk
module bcr_host_model
	import bcr_pkg::*;
(
	input  wire logic        core_clk,
	output logic             wr_en,
	output logic      [3:0]  wr_sel,
	output logic      [15:0] wr_data,
	output logic             wr_fine_ch
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		wr_en      = 1'b0;
		wr_sel     = 4'h0;
		wr_data    = 16'h0000;
		wr_fine_ch = 1'b0;
	end

	// ====================
	// one word per write, held across the taking edge
	task automatic write(input logic [3:0] sel, input logic [15:0] data, input logic ch);
		wr_en      = 1'b1;
		wr_sel     = sel;
		wr_data    = (sel == SEL_SCAN_CTRL) ? (data & ~SCAN_RSV_MSK) : data;
		wr_fine_ch = ch;
		@(negedge core_clk);
	endtask : write

	// released data lines show the inverse so stale data is never mistaken
	task automatic idle();
		wr_en   = 1'b0;
		wr_data = ~wr_data;
		@(negedge core_clk);
	endtask : idle

endmodule : bcr_host_model

// >>> bias_ctrl_config_regs_test.sv
// bias_ctrl_config_regs_test: self-checking bench for the bias control register bank
// assumes: host model drives the write side; bench drives reset, reads and alarm levels
module bias_ctrl_config_regs_test
	import bcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        core_clk, resetn, wr_en, wr_fine_ch, fault_ch1, fault_ch2, alert_active;
	logic [3:0]  wr_sel, rd_sel;
	logic [15:0] wr_data, rd_data;
	logic        protect_out_ch1, protect_oe_ch1, protect_out_ch2, protect_oe_ch2;
	logic        alert_out, alert_oe, repeat_scan, scan_start, result_queue_clear;
	logic        global_powerdown, reference_force_on, oscillator_powerdown;
	logic        converter_off_ch1, converter_off_ch2;
	logic [6:0]  scan_select;
	logic [7:0]  upper_wiper_out_ch1, upper_wiper_out_ch2, lower_wiper_out_ch1, lower_wiper_out_ch2;
	logic [9:0]  fine_out_ch1, fine_out_ch2, fa, fb;
	logic [1:0]  fine_cal_apply;
	logic [3:0]  wiper_autocal_start, cal;
	logic [31:0] seed = 32'h0000BFA1;
	logic [31:0] r;
	logic [7:0]  code [4];
	logic [3:0]  wsel [4] = '{SEL_WIPE_HI1, SEL_WIPE_HI2, SEL_WIPE_LO1, SEL_WIPE_LO2};
	logic [3:0]  tsel [4] = '{SEL_THRU_HI1, SEL_THRU_HI2, SEL_THRU_LO1, SEL_THRU_LO2};
	logic [15:0] acfg [3] = '{16'h0080, 16'h00C4, 16'hFF38};
	logic [15:0] apin [3] = '{16'h0035, 16'h000F, 16'h003D};
	int          q_id [$];
	logic [15:0] q_exp [$];
	int          miscompares = 0;
	int          n_checks = 0;
	int          cycles = 0;

	bcr_regs u_bcr_regs (.core_clk(core_clk), .resetn(resetn), .wr_en(wr_en), .wr_sel(wr_sel),
		.wr_data(wr_data), .wr_fine_ch(wr_fine_ch), .rd_sel(rd_sel), .rd_data(rd_data),
		.fault_ch1(fault_ch1), .fault_ch2(fault_ch2), .alert_active(alert_active),
		.protect_out_ch1(protect_out_ch1), .protect_oe_ch1(protect_oe_ch1),
		.protect_out_ch2(protect_out_ch2), .protect_oe_ch2(protect_oe_ch2),
		.alert_out(alert_out), .alert_oe(alert_oe), .repeat_scan(repeat_scan),
		.scan_select(scan_select), .scan_start(scan_start),
		.result_queue_clear(result_queue_clear), .global_powerdown(global_powerdown),
		.reference_force_on(reference_force_on), .oscillator_powerdown(oscillator_powerdown),
		.converter_off_ch1(converter_off_ch1), .converter_off_ch2(converter_off_ch2),
		.upper_wiper_out_ch1(upper_wiper_out_ch1), .upper_wiper_out_ch2(upper_wiper_out_ch2),
		.lower_wiper_out_ch1(lower_wiper_out_ch1), .lower_wiper_out_ch2(lower_wiper_out_ch2),
		.fine_out_ch1(fine_out_ch1), .fine_out_ch2(fine_out_ch2),
		.fine_cal_apply(fine_cal_apply), .wiper_autocal_start(wiper_autocal_start));

	bcr_host_model u_bcr_host_model (.core_clk(core_clk), .wr_en(wr_en), .wr_sel(wr_sel),
		.wr_data(wr_data), .wr_fine_ch(wr_fine_ch));

	// ====================
	// clock, timeout, helpers
	initial core_clk = 1'b0;
	always #12.5 core_clk = ~core_clk;

	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			miscompares++;
			print_verdict();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [15:0] obs(input int id);
		case (id)
			0: obs = {8'h00, upper_wiper_out_ch1};
			1: obs = {8'h00, upper_wiper_out_ch2};
			2: obs = {8'h00, lower_wiper_out_ch1};
			3: obs = {8'h00, lower_wiper_out_ch2};
			4: obs = {6'h00, fine_out_ch1};
			5: obs = {6'h00, fine_out_ch2};
			6: obs = {14'h0000, fine_cal_apply};
			7: obs = {12'h000, wiper_autocal_start};
			8: obs = {11'h000, global_powerdown, reference_force_on, oscillator_powerdown,
				converter_off_ch2, converter_off_ch1};
			9: obs = {8'h00, repeat_scan, scan_select};
			10: obs = {14'h0000, result_queue_clear, scan_start};
			11: obs = {10'h000, protect_out_ch1, protect_oe_ch1, protect_out_ch2, protect_oe_ch2,
				alert_out, alert_oe};
			default: obs = rd_data;
		endcase
	endfunction : obs

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic note(input int id, input logic [15:0] v);
		q_id.push_back(id);
		q_exp.push_back(v);
	endtask : note

	// rd_sel and the notes change at the falling edge, so sample a little later
	always @(negedge core_clk)
	begin
		#2;
		while (q_id.size() > 0)
			chk(obs(q_id.pop_front()), q_exp.pop_front());
	end

	task automatic wr(input logic [3:0] sel, input logic [15:0] d, input logic ch);
		u_bcr_host_model.write(sel, d, ch);
		u_bcr_host_model.idle();
	endtask : wr

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	// ====================
	// main sequence
	initial
	begin
		resetn = 1'b0;
		rd_sel = SEL_ALARM_CFG;
		fault_ch1 = 1'b0;
		fault_ch2 = 1'b0;
		alert_active = 1'b0;
		repeat (8) @(negedge core_clk);
		resetn = 1'b1;
		repeat (4) @(negedge core_clk);
		note(8, 16'h0017);
		note(11, 16'h0015);
		note(12, 16'h0000);
		$display("test reset done");
		wr(SEL_SHUTDOWN, 16'h000C, 1'b0);
		note(8, 16'h0003);
		wr(SEL_SHUTDOWN, 16'h000C, 1'b0);
		note(8, 16'h000C);
		wr(SEL_SHUTDOWN, 16'h0000, 1'b0);
		note(8, 16'h0000);
		$display("test shutdown done");
		for (int i = 0; i < 8; i++)
		begin
			u_bcr_host_model.write(SEL_SCAN_CTRL, 16'h0001 << i, 1'b0);
			note(9, 16'h0001 << i);
			note(10, 16'h0001);
			u_bcr_host_model.idle();
		end
		$display("test scan done");
		for (int i = 0; i < 3; i++)
		begin
			alert_active = (i > 0);
			fault_ch2 = (i == 2);
			wr(SEL_ALARM_CFG, acfg[i], 1'b0);
			note(11, apin[i]);
			note(12, acfg[i] & 16'h00FF);
		end
		$display("test pins done");
		for (int i = 0; i < 4; i++)
		begin
			r = rnd();
			code[i] = r[7:0];
			cal[i] = r[8];
			wr(wsel[i], {cal[i], 7'h00, code[i]}, 1'b0);
		end
		u_bcr_host_model.write(SEL_LOAD, 16'hFFDB, 1'b0);
		for (int i = 0; i < 4; i++)
			note(i, {8'h00, code[i]});
		note(7, {12'h000, cal});
		u_bcr_host_model.idle();
		note(7, 16'h0000);
		rd_sel = SEL_WIPE_LO2;
		note(12, {cal[3], 7'h00, code[3]});
		$display("test load done");
		u_bcr_host_model.write(SEL_CLEAR, 16'h0040, 1'b0);
		note(10, 16'h0002);
		u_bcr_host_model.idle();
		wr(SEL_CLEAR, 16'h0036, 1'b0);
		for (int i = 0; i < 4; i++)
			note(i, 16'h0000);
		u_bcr_host_model.write(SEL_LOAD, 16'h001B, 1'b0);
		note(7, 16'h000F);
		u_bcr_host_model.idle();
		$display("test clear done");
		for (int i = 0; i < 4; i++)
		begin
			r = rnd();
			code[i] = r[7:0];
			u_bcr_host_model.write(tsel[i], r[15:0], 1'b0);
			note(i, {8'h00, code[i]});
			note(7, 16'h0000);
			u_bcr_host_model.idle();
			rd_sel = tsel[i];
			note(12, {8'h00, code[i]});
		end
		$display("test thru done");
		r = rnd();
		fa = r[9:0];
		fb = r[19:10];
		wr(SEL_FINE_CH1, {6'h00, fa}, 1'b0);
		wr(SEL_FINECAL, {6'h00, fb}, 1'b0);
		wr(SEL_LOAD, 16'h0004, 1'b0);
		note(4, {6'h00, fb});
		note(6, 16'h0001);
		wr(SEL_FINECAL, {6'h00, fb}, 1'b1);
		wr(SEL_FINE_CH2, {6'h00, fa}, 1'b0);
		wr(SEL_LOAD, 16'h0020, 1'b0);
		note(5, {6'h00, fa});
		note(6, 16'h0001);
		$display("test fine done");
		wr(SEL_CLEAR, 16'h0100, 1'b0);
		wr(SEL_SCAN_CTRL, 16'h0000, 1'b0);
		u_bcr_host_model.write(SEL_CLEAR, 16'h0200, 1'b0);
		note(10, 16'h0000);
		u_bcr_host_model.idle();
		note(8, 16'h0000);
		u_bcr_host_model.write(SEL_CLEAR, 16'h0100, 1'b0);
		u_bcr_host_model.write(SEL_CLEAR, 16'h0200, 1'b0);
		note(10, 16'h0002);
		u_bcr_host_model.idle();
		note(8, 16'h0017);
		note(5, 16'h0000);
		wr(SEL_SHUTDOWN, 16'h000C, 1'b0);
		note(8, 16'h0003);
		$display("test full reset done");
		@(negedge core_clk);
		print_verdict();
	end

endmodule : bias_ctrl_config_regs_test
